// ### src/aiopf_top.sv
`timescale 1ns/10ps
`default_nettype none
module aiopf_top (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire aiopf_pkg::aiopf_req_t bus_req,
  output logic [31:0] bus_rdata,
  output logic dac_sclk,
  output logic dac_sdo,
  output logic dac_sync_n,
  output logic dac_load_strobe,
  output logic adc_convert,
  output logic [2:0] adc_channel,
  output logic [2:0] input_range_code,
  input wire logic adc_done,
  input wire aiopf_pkg::aiopf_sample_t adc_sample,
  input wire logic dma_pop,
  output logic [63:0] dma_data,
  output logic almost_full
);
  import aiopf_pkg::*;

  // software registers
  logic [31:0] wave_div_reg;
  logic [31:0] start_div_reg;
  logic [31:0] scan_div_reg;
  logic [31:0] range_reg;
  logic [11:0] af_level_reg;
  logic [3:0] wpp_reg;
  logic scan_mode_reg;
  logic go_reg;
  logic [2:0] last_ch_reg;
  logic [1:0] seqmode_reg;
  logic [2:0] gain_reg;
  // decoded strobes
  logic wr_cmd, rd_cmd, wr_wave, rd_fifo;
  assign wr_cmd = bus_req.wr && (bus_req.addr == AIOPF_OFS_DAC_CMD);
  assign rd_cmd = bus_req.rd && (bus_req.addr == AIOPF_OFS_DAC_CMD);
  assign wr_wave = bus_req.wr && (bus_req.addr == AIOPF_OFS_WAVE_FIFO);
  assign rd_fifo = bus_req.rd && (bus_req.addr == AIOPF_OFS_FIFO_READ);

  // register writes; full-word only, host never splits
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wave_div_reg <= AIOPF_RST_ZERO;
      start_div_reg <= AIOPF_RST_ZERO;
      scan_div_reg <= AIOPF_RST_ZERO;
      range_reg <= AIOPF_RST_ZERO;
      af_level_reg <= 12'h000;
      wpp_reg <= AIOPF_RST_WPP;
      scan_mode_reg <= 1'b0;
      go_reg <= 1'b0;
      last_ch_reg <= 3'h0;
      seqmode_reg <= 2'h0;
      gain_reg <= 3'h0;
    end else if (bus_req.wr) begin
      unique case (bus_req.addr)
        AIOPF_OFS_WAVE_DIV: wave_div_reg <= bus_req.wdata;
        AIOPF_OFS_START_DIV: start_div_reg <= bus_req.wdata;
        AIOPF_OFS_SCAN_DIV: scan_div_reg <= bus_req.wdata;
        AIOPF_OFS_RANGE: range_reg <= bus_req.wdata;
        AIOPF_OFS_AF_LEVEL: af_level_reg <= bus_req.wdata[11:0];
        AIOPF_OFS_WORDS_PER_PT: begin
          // clamp to 1..8 words per point
          if (bus_req.wdata[3:0] == 4'h0) wpp_reg <= AIOPF_RST_WPP;
          else if (bus_req.wdata[3:0] > 4'h8) wpp_reg <= 4'h8;
          else wpp_reg <= bus_req.wdata[3:0];
        end
        AIOPF_OFS_CTRL: begin
          scan_mode_reg <= bus_req.wdata[AIOPF_BIT_SCAN];
          go_reg <= bus_req.wdata[AIOPF_BIT_GO];
          last_ch_reg <= bus_req.wdata[AIOPF_LAST_CH_LSB +: 3];
          seqmode_reg <= bus_req.wdata[5:4];
          gain_reg <= bus_req.wdata[8:6];
        end
        default: ;
      endcase
    end
  end

  // waveform playback fifo
  logic [23:0] wave_mem [AIOPF_WAVE_DEPTH];
  logic [7:0] wave_wp_reg, wave_rp_reg;
  logic [8:0] wave_cnt_reg;
  logic wave_pop;
  always_ff @(posedge sys_clk) begin
    if (wr_wave && wave_cnt_reg != 9'(AIOPF_WAVE_DEPTH)) wave_mem[wave_wp_reg] <= bus_req.wdata[23:0];
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wave_wp_reg <= 8'h00;
      wave_rp_reg <= 8'h00;
      wave_cnt_reg <= 9'h000;
    end else begin
      if (wr_wave && wave_cnt_reg != 9'(AIOPF_WAVE_DEPTH)) wave_wp_reg <= wave_wp_reg + 8'h01;
      if (wave_pop) wave_rp_reg <= wave_rp_reg + 8'h01;
      wave_cnt_reg <= wave_cnt_reg + 9'((wr_wave && wave_cnt_reg != 9'(AIOPF_WAVE_DEPTH)) ? 1 : 0)
        - 9'(wave_pop ? 1 : 0);
    end
  end

  // 25 MHz prescale and pacing counter
  logic [1:0] pre_reg;
  logic [31:0] pace_cnt_reg;
  logic pace_tick;
  assign pace_tick = (pre_reg == AIOPF_DAC_PRESCALE - 2'h1) && (wave_div_reg != 32'h0000_0000)
    && (pace_cnt_reg >= wave_div_reg - 32'h0000_0001);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_reg <= 2'h0;
      pace_cnt_reg <= AIOPF_RST_ZERO;
    end else begin
      pre_reg <= (pre_reg == AIOPF_DAC_PRESCALE - 2'h1) ? 2'h0 : pre_reg + 2'h1;
      if (pre_reg == AIOPF_DAC_PRESCALE - 2'h1) begin
        pace_cnt_reg <= pace_tick ? AIOPF_RST_ZERO : pace_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // dac serial shifter: host commands have priority only when idle
  logic busy_reg, loaded_reg, sclk_phase_reg;
  logic [23:0] shift_reg;
  logic [4:0] bit_cnt_reg;
  logic [3:0] pt_left_reg;
  // next word only once the link is idle, so every word gets its own select frame
  assign wave_pop = !busy_reg && !wr_cmd && (pt_left_reg != 4'h0)
    && (wave_cnt_reg != 9'h000) && !pace_tick;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_reg <= 1'b0;
      sclk_phase_reg <= 1'b0;
      shift_reg <= 24'h00_0000;
      bit_cnt_reg <= 5'h00;
      pt_left_reg <= 4'h0;
      dac_load_strobe <= 1'b0;
      dac_sclk <= 1'b0;
      dac_sdo <= 1'b0;
      dac_sync_n <= 1'b1;
    end else begin
      dac_load_strobe <= pace_tick;
      if (pace_tick) pt_left_reg <= wpp_reg;
      else if (wave_pop) pt_left_reg <= pt_left_reg - 4'h1;
      if (wr_cmd && !busy_reg) begin
        // host command word, packet error checking not supported
        shift_reg <= bus_req.wdata[23:0];
        busy_reg <= 1'b1;
        bit_cnt_reg <= AIOPF_DAC_BITS;
        sclk_phase_reg <= 1'b0;
      end else if (wave_pop) begin
        shift_reg <= wave_mem[wave_rp_reg];
        busy_reg <= 1'b1;
        bit_cnt_reg <= AIOPF_DAC_BITS;
        sclk_phase_reg <= 1'b0;
      end else if (busy_reg) begin
        sclk_phase_reg <= !sclk_phase_reg;
        if (sclk_phase_reg) begin
          shift_reg <= {shift_reg[22:0], 1'b0};
          bit_cnt_reg <= bit_cnt_reg - 5'h01;
          if (bit_cnt_reg == 5'h01) busy_reg <= 1'b0;
        end
      end
      dac_sync_n <= !busy_reg;
      dac_sdo <= shift_reg[23];
      dac_sclk <= busy_reg && sclk_phase_reg;
    end
  end

  // load flag: set wins over read-clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) loaded_reg <= 1'b0;
    else if (pace_tick) loaded_reg <= 1'b1;
    else if (rd_cmd) loaded_reg <= 1'b0;
  end

  // adc start pacing and scan sequencer
  aiopf_seq_t seq_reg;
  logic [31:0] start_cnt_reg, scan_cnt_reg;
  logic [2:0] ch_reg;
  logic start_ev, scan_ok;
  assign scan_ok = scan_mode_reg && (seqmode_reg != 2'b00) && (last_ch_reg != 3'h0);
  assign start_ev = go_reg && (start_div_reg != 32'h0000_0000)
    && (start_cnt_reg >= start_div_reg - 32'h0000_0001);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) start_cnt_reg <= AIOPF_RST_ZERO;
    else if (!go_reg || start_ev) start_cnt_reg <= AIOPF_RST_ZERO;
    else start_cnt_reg <= start_cnt_reg + 32'h0000_0001;
  end
  logic sw_start;
  assign sw_start = bus_req.wr && (bus_req.addr == AIOPF_OFS_CTRL) && bus_req.wdata[AIOPF_BIT_GO]
    && (start_div_reg == 32'h0000_0000);
  // software start acted on a cycle late, once channel and gain fields have landed
  logic sw_start_reg;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) sw_start_reg <= 1'b0;
    else sw_start_reg <= sw_start;
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_reg <= AIOPF_IDLE;
      scan_cnt_reg <= AIOPF_RST_ZERO;
      ch_reg <= 3'h0;
      adc_convert <= 1'b0;
      adc_channel <= 3'h0;
      input_range_code <= 3'h0;
    end else begin
      adc_convert <= 1'b0;
      unique case (seq_reg)
        AIOPF_IDLE: begin
          if (start_ev || sw_start_reg) begin
            adc_convert <= 1'b1;
            adc_channel <= (seqmode_reg == 2'b00) ? last_ch_reg : ch_reg;
            // per-channel range only in advanced mode
            input_range_code <= (seqmode_reg == 2'b10) ? range_reg[{ch_reg, 2'b00} +: 3] : gain_reg;
            scan_cnt_reg <= AIOPF_RST_ZERO;
            if (seqmode_reg != 2'b00) ch_reg <= (ch_reg >= last_ch_reg) ? 3'h0 : ch_reg + 3'h1;
            if (scan_ok && ch_reg < last_ch_reg) seq_reg <= AIOPF_WAIT;
          end
        end
        AIOPF_WAIT: begin
          scan_cnt_reg <= scan_cnt_reg + 32'h0000_0001;
          // leave early by one so the conversion edge lands exactly one divisor later
          if (scan_cnt_reg + 32'h0000_0002 >= scan_div_reg) seq_reg <= AIOPF_CONV;
        end
        AIOPF_CONV: begin
          adc_convert <= 1'b1;
          adc_channel <= ch_reg;
          input_range_code <= (seqmode_reg == 2'b10) ? range_reg[{ch_reg, 2'b00} +: 3] : gain_reg;
          scan_cnt_reg <= AIOPF_RST_ZERO;
          ch_reg <= (ch_reg >= last_ch_reg) ? 3'h0 : ch_reg + 3'h1;
          seq_reg <= (ch_reg >= last_ch_reg) ? AIOPF_IDLE : AIOPF_WAIT;
        end
        default: seq_reg <= AIOPF_IDLE;
      endcase
    end
  end
  // tag each result with channel and range of its conversion
  logic [2:0] conv_ch_reg, conv_rng_reg;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_ch_reg <= 3'h0;
      conv_rng_reg <= 3'h0;
    end else if (adc_convert) begin
      conv_ch_reg <= adc_channel;
      conv_rng_reg <= input_range_code;
    end
  end
  logic [31:0] res_word;
  assign res_word = {1'b0, go_reg, adc_sample.dio, adc_sample.temp, adc_sample.aux, 1'b0, conv_ch_reg,
    adc_sample.diff, conv_rng_reg, adc_sample.counts};

  // result fifo: 64-bit entries, low half only when software start
  logic pair_mode;
  assign pair_mode = (start_div_reg != 32'h0000_0000);
  logic [63:0] res_mem [AIOPF_RES_DEPTH];
  logic [11:0] res_wp_reg, res_rp_reg, res_cnt_reg;
  logic [31:0] half_reg;
  logic half_full_reg, rd_hi_reg;
  logic res_push, res_pop;
  logic [63:0] res_entry;
  assign res_push = adc_done && (res_cnt_reg != AIOPF_RES_MAX) && (!pair_mode || half_full_reg);
  assign res_entry = pair_mode ? {res_word, half_reg} : {32'h0000_0000, res_word};
  assign res_pop = (res_cnt_reg != 12'h000) && (dma_pop || (rd_fifo && (!pair_mode || rd_hi_reg)));
  always_ff @(posedge sys_clk) begin
    if (res_push) res_mem[res_wp_reg] <= res_entry;
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      res_wp_reg <= 12'h000;
      res_rp_reg <= 12'h000;
      res_cnt_reg <= 12'h000;
      half_reg <= AIOPF_RST_ZERO;
      half_full_reg <= 1'b0;
      rd_hi_reg <= 1'b0;
    end else begin
      if (adc_done && pair_mode && !half_full_reg) begin
        half_reg <= res_word;
        half_full_reg <= 1'b1;
      end else if (adc_done) half_full_reg <= 1'b0;
      if (res_push) res_wp_reg <= res_wp_reg + 12'h001;
      if (res_pop) res_rp_reg <= res_rp_reg + 12'h001;
      res_cnt_reg <= res_cnt_reg + 12'(res_push ? 1 : 0) - 12'(res_pop ? 1 : 0);
      if (rd_fifo && pair_mode && res_cnt_reg != 12'h000) rd_hi_reg <= !rd_hi_reg;
    end
  end

  // read mux and registered outputs
  logic [31:0] rdata_next;
  always_comb begin
    rdata_next = AIOPF_RST_ZERO;
    unique case (bus_req.addr)
      AIOPF_OFS_DAC_CMD: begin
        rdata_next[AIOPF_BIT_BUSY] = busy_reg;
        rdata_next[AIOPF_BIT_LOADED] = loaded_reg;
        rdata_next[AIOPF_BIT_WEMPTY] = (wave_cnt_reg == 9'h000);
        rdata_next[AIOPF_BIT_WHALF] = (wave_cnt_reg < AIOPF_WAVE_HALF);
      end
      AIOPF_OFS_WAVE_DIV: rdata_next = wave_div_reg;
      AIOPF_OFS_BASE_FREQ: rdata_next = AIOPF_ADC_BASE_HZ;
      AIOPF_OFS_START_DIV: rdata_next = start_div_reg;
      AIOPF_OFS_SCAN_DIV: rdata_next = scan_div_reg;
      AIOPF_OFS_RANGE: rdata_next = range_reg;
      AIOPF_OFS_AF_LEVEL: rdata_next = {20'h0_0000, af_level_reg};
      AIOPF_OFS_FIFO_LEVEL: rdata_next = {20'h0_0000, res_cnt_reg};
      AIOPF_OFS_FIFO_READ: begin
        if (res_cnt_reg == 12'h000) rdata_next[31] = 1'b1;
        else rdata_next = rd_hi_reg ? res_mem[res_rp_reg][63:32] : res_mem[res_rp_reg][31:0];
      end
      AIOPF_OFS_WAVE_FIFO: rdata_next = {23'h00_0000, wave_cnt_reg};
      default: rdata_next = AIOPF_RST_ZERO;
    endcase
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata <= AIOPF_RST_ZERO;
      dma_data <= 64'h0000_0000_0000_0000;
      almost_full <= 1'b0;
    end else begin
      if (bus_req.rd) bus_rdata <= rdata_next;
      dma_data <= res_mem[res_rp_reg];
      almost_full <= (res_cnt_reg >= af_level_reg);
    end
  end
endmodule // aiopf_top
`default_nettype wire

// ### inc/aiopf_pkg.sv
package aiopf_pkg;
  // register byte offsets
  localparam logic [7:0] AIOPF_OFS_DAC_CMD = 8'h04;
  localparam logic [7:0] AIOPF_OFS_WAVE_DIV = 8'h08;
  localparam logic [7:0] AIOPF_OFS_BASE_FREQ = 8'h0c;
  localparam logic [7:0] AIOPF_OFS_START_DIV = 8'h10;
  localparam logic [7:0] AIOPF_OFS_SCAN_DIV = 8'h14;
  localparam logic [7:0] AIOPF_OFS_RANGE = 8'h18;
  localparam logic [7:0] AIOPF_OFS_AF_LEVEL = 8'h20;
  localparam logic [7:0] AIOPF_OFS_FIFO_LEVEL = 8'h28;
  localparam logic [7:0] AIOPF_OFS_FIFO_READ = 8'h30;
  localparam logic [7:0] AIOPF_OFS_CTRL = 8'h38;
  localparam logic [7:0] AIOPF_OFS_WAVE_FIFO = 8'h50;
  localparam logic [7:0] AIOPF_OFS_WORDS_PER_PT = 8'h54;
  // status bit positions of the dac command register
  localparam int AIOPF_BIT_BUSY = 31;
  localparam int AIOPF_BIT_LOADED = 30;
  localparam int AIOPF_BIT_WEMPTY = 29;
  localparam int AIOPF_BIT_WHALF = 28;
  // control register bit positions
  localparam int AIOPF_BIT_SCAN = 18;
  localparam int AIOPF_BIT_GO = 16;
  localparam int AIOPF_LAST_CH_LSB = 12;
  // adc base clock in hertz, equals sys_clk rate
  localparam logic [31:0] AIOPF_ADC_BASE_HZ = 32'h02fa_f080;
  // dac pacing base is 25 MHz: one count every 2 sys_clk cycles
  localparam int AIOPF_SYS_HZ = 50000000;
  localparam int AIOPF_DAC_BASE_HZ = 25000000;
  localparam logic [1:0] AIOPF_DAC_PRESCALE = 2'(AIOPF_SYS_HZ / AIOPF_DAC_BASE_HZ);
  // serial shift length of one dac command word
  localparam logic [4:0] AIOPF_DAC_BITS = 5'h18;
  // fifo sizes
  localparam int AIOPF_WAVE_DEPTH = 256;
  localparam logic [8:0] AIOPF_WAVE_HALF = 9'h080;
  localparam int AIOPF_RES_DEPTH = 4096;
  localparam logic [11:0] AIOPF_RES_MAX = 12'hfff;
  // reset values and reserved range code
  localparam logic [31:0] AIOPF_RST_ZERO = 32'h0000_0000;
  localparam logic [3:0] AIOPF_RST_WPP = 4'h1;
  localparam logic [3:0] AIOPF_RANGE_RSV = 4'h6;
  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } aiopf_req_t;
  // one conversion result from the adc front end
  typedef struct packed {
    logic [3:0] dio;
    logic temp;
    logic aux;
    logic diff;
    logic [15:0] counts;
  } aiopf_sample_t;
  // adc sequencer states
  typedef enum logic [1:0] {
    AIOPF_IDLE = 2'b00,
    AIOPF_WAIT = 2'b01,
    AIOPF_CONV = 2'b11
  } aiopf_seq_t;
endpackage

// ### dv/aiopf_props.sv
`timescale 1ns/10ps
`default_nettype none
// concurrent checks on the host bus and converter links
module aiopf_props (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire aiopf_pkg::aiopf_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic dac_sync_n,
  input wire logic dac_load_strobe,
  input wire logic adc_convert,
  input wire logic [2:0] input_range_code
);
  import aiopf_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // start of one dac word frame
  sequence s_frame_start;
    $fell(dac_sync_n);
  endsequence
  // select held through the first bits
  sequence s_low8;
    !dac_sync_n [*8];
  endsequence
  // two bus cycles in a row without a read
  sequence s_bus_quiet;
    !bus_req.rd ##1 !bus_req.rd;
  endsequence
  chk_load_single: assert property (dac_load_strobe |=> !dac_load_strobe)
    else $error("load strobe longer than one cycle");
  chk_load_idle_link: assert property (dac_load_strobe |-> dac_sync_n)
    else $error("load strobe during a word frame");
  chk_conv_single: assert property (adc_convert |=> !adc_convert)
    else $error("convert longer than one cycle");
  chk_range_legal: assert property (adc_convert |-> input_range_code != 3'h6)
    else $error("reserved range code driven");
  chk_frame_hold: assert property (s_frame_start |-> s_low8)
    else $error("word frame too short");
  chk_frame_ends: assert property (s_frame_start |-> ##[40:60] dac_sync_n)
    else $error("word frame not ended in time");
  chk_base_hertz: assert property (bus_req.rd && bus_req.addr == AIOPF_OFS_BASE_FREQ
    |-> ##2 bus_rdata == AIOPF_ADC_BASE_HZ)
    else $error("base frequency read wrong");
  chk_rdata_holds: assert property (s_bus_quiet |=> $stable(bus_rdata))
    else $error("read data changed without a read");
endmodule // aiopf_props
`default_nettype wire

// ### dv/aiopf_adc_model.sv
`timescale 1ns/10ps
`default_nettype none
// converter front end: done pulse three cycles after a start
module aiopf_adc_model (
  input wire logic sys_clk,
  input wire logic adc_convert,
  input wire logic [2:0] adc_channel,
  output logic adc_done,
  output aiopf_pkg::aiopf_sample_t adc_sample
);
  import aiopf_pkg::*;
  logic [2:0] ch_reg; // channel of the pending conversion
  int wait_n; // cycles left until done
  // sample only valid with done; toggles otherwise
  initial begin
    adc_done = 1'b0;
    adc_sample = '0;
    ch_reg = 3'h0;
    wait_n = 0;
    forever begin
      @(posedge sys_clk);
      #2 adc_done = 1'b0;
      adc_sample = ~adc_sample;
      if (adc_convert === 1'b1) begin
        ch_reg = adc_channel;
        wait_n = 3;
      end else if (wait_n > 0) begin
        wait_n--;
        if (wait_n == 0) begin
          adc_done = 1'b1;
          adc_sample = '{dio: 4'ha, temp: 1'b0, aux: 1'b0, diff: 1'b0, counts: {13'h0248, ch_reg}};
        end
      end
    end
  end
endmodule // aiopf_adc_model
`default_nettype wire

// ### dv/aiopf_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module aiopf_top_tb;
  import aiopf_pkg::*;
  logic sys_clk, reset_n, dac_sclk, dac_sdo, dac_sync_n, dac_load_strobe;
  logic adc_convert, adc_done, dma_pop, almost_full;
  logic [2:0] adc_channel, input_range_code;
  logic [31:0] bus_rdata;
  logic [63:0] dma_data;
  aiopf_req_t bus_req;
  aiopf_sample_t adc_sample;
  int n_fail = 0;
  int n_compared = 0;
  int cyc_n = 0;
  aiopf_top i_aiopf_top (.sys_clk(sys_clk), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .dac_sclk(dac_sclk), .dac_sdo(dac_sdo), .dac_sync_n(dac_sync_n), .dac_load_strobe(dac_load_strobe),
    .adc_convert(adc_convert), .adc_channel(adc_channel), .input_range_code(input_range_code),
    .adc_done(adc_done), .adc_sample(adc_sample), .dma_pop(dma_pop), .dma_data(dma_data),
    .almost_full(almost_full));
  aiopf_adc_model i_aiopf_adc_model (.sys_clk(sys_clk), .adc_convert(adc_convert),
    .adc_channel(adc_channel), .adc_done(adc_done), .adc_sample(adc_sample));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // cycle count and hang guard
  always @(posedge sys_clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_fail++;
      $display("timeout reached");
      print_verdict;
    end
  end
  task automatic print_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  // one-cycle write, then a quiet cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk); #2 bus_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk); #2 bus_req = '0;
  endtask
  // read data taken once the answer has settled
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk); #2 bus_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge sys_clk); #2 bus_req = '0;
    @(posedge sys_clk); #2 d = bus_rdata;
  endtask
  task automatic wait_conv(output int t);
    int n;
    n = 0;
    do begin @(posedge sys_clk); #1 n++; end while (adc_convert !== 1'b1 && n < 600);
    chk("convert seen", 32'h1, {31'h0, adc_convert});
    t = cyc_n;
  endtask
  // waits for a load strobe, counting word frames begun meanwhile
  task automatic wait_strobe(output int t, output int f);
    int n;
    logic p;
    n = 0;
    f = 0;
    p = dac_sync_n;
    do begin
      @(posedge sys_clk); #1 n++;
      if (p && !dac_sync_n) f++;
      p = dac_sync_n;
    end while (dac_load_strobe !== 1'b1 && n < 600);
    chk("strobe seen", 32'h1, {31'h0, dac_load_strobe});
    t = cyc_n;
  endtask
  task automatic t_regs;
    logic [31:0] d;
    rd(AIOPF_OFS_BASE_FREQ, d); chk("base hz", AIOPF_ADC_BASE_HZ, d);
    rd(8'h40, d); chk("unmapped", 32'h0000_0000, d);
    wr(AIOPF_OFS_AF_LEVEL, 32'hffff_f123);
    rd(AIOPF_OFS_AF_LEVEL, d); chk("af level", 32'h0000_0123, d & 32'h0000_0fff);
    wr(AIOPF_OFS_RANGE, 32'h0754_3210);
    rd(AIOPF_OFS_RANGE, d); chk("range reg", 32'h0754_3210, d & 32'h7777_7777);
    $display("test regs done");
  endtask
  task automatic t_dac_cmd;
    logic [31:0] d;
    logic [23:0] sh;
    int n;
    fork
      begin
        n = 0;
        while (dac_sync_n !== 1'b0 && n < 100) begin @(posedge sys_clk); n++; end
        repeat (24) begin @(posedge dac_sclk); sh = {sh[22:0], dac_sdo}; end
      end
      begin
        wr(AIOPF_OFS_DAC_CMD, 32'hf0a5_5a3c);
        rd(AIOPF_OFS_DAC_CMD, d); chk("busy", 32'h8000_0000, d & 32'h8000_0000);
      end
    join
    chk("cmd word", 32'h00a5_5a3c, {8'h00, sh});
    n = 0;
    do begin rd(AIOPF_OFS_DAC_CMD, d); n++; end while (d[31] !== 1'b0 && n < 40);
    chk("idle flags", 32'h3000_0000, d & 32'hf000_0000);
    $display("test dac command done");
  endtask
  task automatic t_wave;
    logic [31:0] d;
    int t0, t1, f;
    wr(AIOPF_OFS_WORDS_PER_PT, 32'h0000_0002);
    for (int i = 0; i < 4; i++) wr(AIOPF_OFS_WAVE_FIFO, 32'h0010_0000 + i);
    rd(AIOPF_OFS_DAC_CMD, d); chk("fifo flags", 32'h1000_0000, d & 32'h3000_0000);
    wr(AIOPF_OFS_WAVE_DIV, 32'd60);
    wait_strobe(t0, f);
    wait_strobe(t1, f);
    wr(AIOPF_OFS_WAVE_DIV, 32'h0000_0000);
    chk("tick period", 60 * AIOPF_DAC_PRESCALE, t1 - t0);
    chk("words per point", 32'd2, f);
    repeat (110) @(posedge sys_clk);
    rd(AIOPF_OFS_DAC_CMD, d); chk("load set", 32'h7000_0000, d & 32'hf000_0000);
    rd(AIOPF_OFS_DAC_CMD, d); chk("load cleared", 32'h3000_0000, d & 32'hf000_0000);
    $display("test waveform done");
  endtask
  task automatic t_adc_soft;
    logic [31:0] d;
    int t;
    wr(AIOPF_OFS_START_DIV, 32'h0000_0000);
    wr(AIOPF_OFS_CTRL, 32'h0001_5100);
    wait_conv(t);
    chk("single ch", 32'd5, {29'h0, adc_channel});
    chk("single range", 32'd4, {29'h0, input_range_code});
    repeat (10) @(posedge sys_clk);
    rd(AIOPF_OFS_FIFO_LEVEL, d); chk("soft count", 32'd1, d & 32'h0000_0fff);
    rd(AIOPF_OFS_FIFO_READ, d); chk("result word", 32'h2854_1245, d & 32'hbf7f_ffff);
    rd(AIOPF_OFS_FIFO_READ, d); chk("empty read", 32'h8000_0000, d & 32'h8000_0000);
    wr(AIOPF_OFS_CTRL, 32'h0000_5100);
    $display("test software start done");
  endtask
  task automatic t_adc_scan;
    logic [31:0] d;
    int t, tp, ts;
    wr(AIOPF_OFS_SCAN_DIV, 32'd10);
    wr(AIOPF_OFS_AF_LEVEL, 32'd4);
    wr(AIOPF_OFS_START_DIV, 32'd400);
    wr(AIOPF_OFS_CTRL, 32'h0005_7020);
    for (int i = 0; i < 16; i++) begin
      wait_conv(t);
      chk("scan ch", i % 8, {29'h0, adc_channel});
      chk("scan range", (32'h0754_3210 >> (4 * (i % 8))) & 7, {29'h0, input_range_code});
      if (i % 8 != 0) chk("in-scan gap", 32'd10, t - tp);
      if (i == 0) ts = t;
      if (i == 8) chk("start period", 32'd400, t - ts);
      tp = t;
    end
    wr(AIOPF_OFS_CTRL, 32'h0000_7020);
    repeat (10) @(posedge sys_clk);
    rd(AIOPF_OFS_FIFO_LEVEL, d); chk("pair count", 32'd8, d & 32'h0000_0fff);
    chk("almost full", 32'h1, {31'h0, almost_full});
    chk("dma low", 32'h0000_1240, {dma_data[22:20], dma_data[15:0]});
    chk("dma high", 32'h0001_1241, {dma_data[54:52], dma_data[47:32]});
    @(posedge sys_clk); #2 dma_pop = 1'b1;
    @(posedge sys_clk); #2 dma_pop = 1'b0;
    rd(AIOPF_OFS_FIFO_READ, d); chk("pair low", 32'h0002_1242, {d[22:20], d[15:0]});
    rd(AIOPF_OFS_FIFO_READ, d); chk("pair high", 32'h0003_1243, {d[22:20], d[15:0]});
    wr(AIOPF_OFS_AF_LEVEL, 32'd8);
    repeat (3) @(posedge sys_clk);
    chk("below level", 32'h0, {31'h0, almost_full});
    $display("test scan done");
  endtask
  initial begin
    reset_n = 1'b0;
    bus_req = '0;
    dma_pop = 1'b0;
    repeat (8) @(posedge sys_clk);
    #2 reset_n = 1'b1;
    t_regs;
    t_dac_cmd;
    t_wave;
    t_adc_soft;
    t_adc_scan;
    print_verdict;
  end
endmodule // aiopf_top_tb
bind aiopf_top aiopf_props i_aiopf_props (.sys_clk(sys_clk), .reset_n(reset_n), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .dac_sync_n(dac_sync_n), .dac_load_strobe(dac_load_strobe),
  .adc_convert(adc_convert), .input_range_code(input_range_code));
`default_nettype wire
